// ---- tb_ttm_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_ttm_regs;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [4:0] ev = 5'h00;
  wire [31:0] rdata;
  wire irq;
  wire len_err, lb_en, prom_a, prom_b;
  wire [47:0] maca, macb;
  int mismatches = 0, checked = 0;
  always #20 clk = ~clk;
  ttm_regs ttm_regs_i (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CHK_MISMATCH(ev[0]), .MACA_RX_OVF(ev[1]), .MACA_RX_RESET(ev[2]),
    .MACB_RX_OVF(ev[3]), .MACB_RX_RESET(ev[4]), .GEN_ENABLE(), .PKT_LENGTH(),
    .PKT_LENGTH_ERR(len_err), .CHK_ENABLE(), .LOOPBACK_ENABLE(lb_en), .SEQ_WRAP(),
    .MACA_PROMISC(prom_a), .MACA_ADDR(maca), .MACB_PROMISC(prom_b), .MACB_ADDR(macb),
    .IRQ(irq));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each task that drives a strobe waits an edge first, so a strobe is never driven twice in one step
  task automatic wt(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rt(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #5 cmp(rdata, e);
  endtask
  task automatic wrt(input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
    wt(a, d);
    rt(a, e);
  endtask
  task automatic pls(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rt(16'h9204, 32'h0000_1000);
    rt(16'h9210, 32'h0000_01ff);
    rt(16'h9404, 32'haabb_ccdd);
    rt(16'h9408, 32'h0000_eeff);
    rt(16'h9410, 32'haaaa_cccc);
    rt(16'h9414, 32'h0000_eeee);
    cmp({16'h0000, maca[47:32]}, 32'h0000_eeff);
    cmp(macb[31:0], 32'haaaa_cccc);
    $display("test reset done");
    wt(16'h9200, 32'hffff_ffff);
    rt(16'h9200, 32'h0000_0001);
    wt(16'h9204, 32'hffff_8000);
    rt(16'h9204, 32'h0000_8000);
    cmp({31'h0000_0000, len_err}, 32'h0000_0000);
    wrt(16'h9204, 32'h0000_8001, 32'h0000_8001);
    cmp({31'h0000_0000, len_err}, 32'h0000_0001);
    wt(16'h9210, 32'h0000_0000);
    wrt(16'h9208, 32'hffff_ffff, 32'h0000_0003);
    cmp({31'h0000_0000, lb_en}, 32'h0000_0001);
    wrt(16'h9400, 32'hffff_ffff, 32'h0000_0001);
    cmp({31'h0000_0000, prom_a}, 32'h0000_0001);
    wrt(16'h9408, 32'hffff_abcd, 32'h0000_abcd);
    cmp({16'h0000, maca[47:32]}, 32'h0000_abcd);
    wrt(16'h940c, 32'h7fff_ffff, 32'h0000_0001);
    cmp({31'h0000_0000, prom_b}, 32'h0000_0001);
    wrt(16'h9414, 32'h0000_5a5a, 32'h0000_5a5a);
    cmp({16'h0000, macb[47:32]}, 32'h0000_5a5a);
    wrt(16'h9300, 32'hffff_ffff, 32'h0000_0000);
    $display("test access done");
    pls(5'h01);
    rt(16'h920c, 32'h0000_0001);
    cmp({31'h0000_0000, irq}, 32'h0000_0000);
    wrt(16'h9504, 32'h0000_0007, 32'h0000_0007);
    cmp({31'h0000_0000, irq}, 32'h0000_0001);
    wrt(16'h920c, 32'h0000_0001, 32'h0000_0000);
    wrt(16'h9208, 32'h0000_0000, 32'h0000_0000);
    pls(5'h01);
    rt(16'h920c, 32'h0000_0000);
    pls(5'h0a);
    wrt(16'h9400, 32'h0000_0000, 32'h8000_0000);
    cmp({31'h0000_0000, prom_a}, 32'h0000_0000);
    rt(16'h940c, 32'h8000_0001);
    pls(5'h14);
    rt(16'h9400, 32'h0000_0000);
    rt(16'h940c, 32'h0000_0001);
    wrt(16'h9500, 32'h0000_0007, 32'h0000_0000);
    cmp({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test events done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// ---- ttm_consts.vh ----
`ifndef TTM_CONSTS_VH
`define TTM_CONSTS_VH
`define TTM_AW 16
`define TTM_OFS_GEN_EN 16'h9200
`define TTM_OFS_PKT_LEN 16'h9204
`define TTM_OFS_LB_CHK 16'h9208
`define TTM_OFS_CHK_STAT 16'h920c
`define TTM_OFS_SEQ_WRAP 16'h9210
`define TTM_OFS_MACA_FILT 16'h9400
`define TTM_OFS_MACA_LO 16'h9404
`define TTM_OFS_MACA_HI 16'h9408
`define TTM_OFS_MACB_FILT 16'h940c
`define TTM_OFS_MACB_LO 16'h9410
`define TTM_OFS_MACB_HI 16'h9414
`define TTM_OFS_IRQ_STAT 16'h9500
`define TTM_OFS_IRQ_MASK 16'h9504
`define TTM_RST_PKT_LEN 16'h1000
`define TTM_RST_SEQ_WRAP 32'h0000_01ff
`define TTM_RST_MACA_LO 32'haabb_ccdd
`define TTM_RST_MACA_HI 16'heeff
`define TTM_RST_MACB_LO 32'haaaa_cccc
`define TTM_RST_MACB_HI 16'heeee
`define TTM_PKT_LEN_MAX 16'h8000
`define TTM_HALF_MSB 15
`define TTM_BIT_EN 0
`define TTM_BIT_LB 1
`define TTM_BIT_OVF 31
`define TTM_IRQ_W 3
`define TTM_IRQ_CHK 0
`define TTM_IRQ_OVFA 1
`define TTM_IRQ_OVFB 2
`endif

// ---- ttm_ovf_flag.v ----
`timescale 1ns/1ns
`default_nettype none
// sticky overflow flag, cleared only by rst_n or the MAC receive path reset
module ttm_ovf_flag (
  input wire clk,
  input wire rst_n,
  input wire rx_reset,
  input wire ovf_evt,
  output reg flag_ff,
  output wire rise
);
  reg nxt_flag;
  always @* begin
    nxt_flag = flag_ff;
    if (rx_reset)
      nxt_flag = 1'b0;
    if (ovf_evt)
      nxt_flag = 1'b1;
  end
  assign rise = ovf_evt & ~flag_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end
endmodule
`default_nettype wire

// ---- ttm_regs.v ----
// Operation
// (RULE_01) generator enable bit, starts test traffic
// (RULE_02) packet length field, reset 4096, max 32KB
// (RULE_03) checker enable and loopback enable bits
// (RULE_04) checker mismatch flag, write one clears
// (RULE_05) sequence wrap count, reset 511
// (RULE_06) first MAC promiscuous enable bit
// (RULE_07) first MAC receive overflow readonly flag
// (RULE_08) first MAC station address, two registers
// (RULE_09) second MAC filter control, same layout
// (RULE_10) second MAC station address, two registers
// (RULE_11) undefined bits read zero, ignore writes
// (RULE_12) overflow flags sticky until receive reset
`timescale 1ns/1ns
`default_nettype none
`include "ttm_consts.vh"
module ttm_regs #(
  parameter ADDR_W = `TTM_AW
) (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [ADDR_W-1:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire CHK_MISMATCH,
  input wire MACA_RX_OVF,
  input wire MACA_RX_RESET,
  input wire MACB_RX_OVF,
  input wire MACB_RX_RESET,
  output wire GEN_ENABLE,
  output wire [15:0] PKT_LENGTH,
  output wire PKT_LENGTH_ERR,
  output wire CHK_ENABLE,
  output wire LOOPBACK_ENABLE,
  output wire [31:0] SEQ_WRAP,
  output wire MACA_PROMISC,
  output wire [47:0] MACA_ADDR,
  output wire MACB_PROMISC,
  output wire [47:0] MACB_ADDR,
  output wire IRQ
);
  reg gen_en_ff;
  reg [15:0] pkt_len_ff;
  reg chk_en_ff;
  reg lb_en_ff;
  reg chk_err_ff;
  reg [31:0] wrap_ff;
  reg prom_a_ff;
  reg prom_b_ff;
  reg [31:0] maca_lo_ff;
  reg [15:0] maca_hi_ff;
  reg [31:0] macb_lo_ff;
  reg [15:0] macb_hi_ff;
  reg [`TTM_IRQ_W-1:0] irq_stat_ff;
  reg [`TTM_IRQ_W-1:0] irq_mask_ff;
  reg [31:0] nxt_rdata;
  reg [`TTM_IRQ_W-1:0] nxt_irq_stat;
  wire ovf_a;
  wire ovf_b;
  wire rise_a;
  wire rise_b;
  wire chk_rise;

  function wr_hit;
    input [ADDR_W-1:0] ofs;
    begin
      wr_hit = WR && (ADDR == ofs);
    end
  endfunction

  // each MAC has its own flag so one receive reset never clears the other
  ttm_ovf_flag u_ovf_a (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .rx_reset(MACA_RX_RESET),
    .ovf_evt(MACA_RX_OVF),
    .flag_ff(ovf_a),
    .rise(rise_a)
  ); // RULE_12
  ttm_ovf_flag u_ovf_b (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .rx_reset(MACB_RX_RESET),
    .ovf_evt(MACB_RX_OVF),
    .flag_ff(ovf_b),
    .rise(rise_b)
  ); // RULE_12

  // next values are decoded in one place, one flop per field below
  reg nxt_gen_en;
  reg [15:0] nxt_pkt_len;
  reg nxt_chk_en;
  reg nxt_lb_en;
  reg [31:0] nxt_wrap;
  reg nxt_prom_a;
  reg nxt_prom_b;
  reg [31:0] nxt_maca_lo;
  reg [15:0] nxt_maca_hi;
  reg [31:0] nxt_macb_lo;
  reg [15:0] nxt_macb_hi;
  reg [`TTM_IRQ_W-1:0] nxt_irq_mask;
  always @* begin
    nxt_gen_en = gen_en_ff;
    nxt_pkt_len = pkt_len_ff;
    nxt_chk_en = chk_en_ff;
    nxt_lb_en = lb_en_ff;
    nxt_wrap = wrap_ff;
    nxt_prom_a = prom_a_ff;
    nxt_prom_b = prom_b_ff;
    nxt_maca_lo = maca_lo_ff;
    nxt_maca_hi = maca_hi_ff;
    nxt_macb_lo = macb_lo_ff;
    nxt_macb_hi = macb_hi_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_hit(`TTM_OFS_GEN_EN)) begin
      nxt_gen_en = WDATA[`TTM_BIT_EN]; // RULE_01
    end
    if (wr_hit(`TTM_OFS_PKT_LEN)) begin
      nxt_pkt_len = WDATA[`TTM_HALF_MSB:0]; // RULE_02
    end
    if (wr_hit(`TTM_OFS_LB_CHK)) begin
      nxt_chk_en = WDATA[`TTM_BIT_EN]; // RULE_03
      nxt_lb_en = WDATA[`TTM_BIT_LB]; // RULE_03
    end
    if (wr_hit(`TTM_OFS_SEQ_WRAP)) begin
      nxt_wrap = WDATA; // RULE_05
    end
    if (wr_hit(`TTM_OFS_MACA_FILT)) begin
      nxt_prom_a = WDATA[`TTM_BIT_EN]; // RULE_06
    end
    if (wr_hit(`TTM_OFS_MACB_FILT)) begin
      nxt_prom_b = WDATA[`TTM_BIT_EN]; // RULE_09
    end
    if (wr_hit(`TTM_OFS_MACA_LO)) begin
      nxt_maca_lo = WDATA; // RULE_08
    end
    if (wr_hit(`TTM_OFS_MACA_HI)) begin
      nxt_maca_hi = WDATA[`TTM_HALF_MSB:0]; // RULE_08
    end
    if (wr_hit(`TTM_OFS_MACB_LO)) begin
      nxt_macb_lo = WDATA; // RULE_10
    end
    if (wr_hit(`TTM_OFS_MACB_HI)) begin
      nxt_macb_hi = WDATA[`TTM_HALF_MSB:0]; // RULE_10
    end
    if (wr_hit(`TTM_OFS_IRQ_MASK)) begin
      nxt_irq_mask = WDATA[`TTM_IRQ_W-1:0];
    end
  end

  // reset loads each field's power-up value
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gen_en_ff <= 1'b0;
    end else begin
      gen_en_ff <= nxt_gen_en;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pkt_len_ff <= `TTM_RST_PKT_LEN;
    end else begin
      pkt_len_ff <= nxt_pkt_len;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      chk_en_ff <= 1'b0;
    end else begin
      chk_en_ff <= nxt_chk_en;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lb_en_ff <= 1'b0;
    end else begin
      lb_en_ff <= nxt_lb_en;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wrap_ff <= `TTM_RST_SEQ_WRAP;
    end else begin
      wrap_ff <= nxt_wrap;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prom_a_ff <= 1'b0;
    end else begin
      prom_a_ff <= nxt_prom_a;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prom_b_ff <= 1'b0;
    end else begin
      prom_b_ff <= nxt_prom_b;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      maca_lo_ff <= `TTM_RST_MACA_LO;
    end else begin
      maca_lo_ff <= nxt_maca_lo;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      maca_hi_ff <= `TTM_RST_MACA_HI;
    end else begin
      maca_hi_ff <= nxt_maca_hi;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      macb_lo_ff <= `TTM_RST_MACB_LO;
    end else begin
      macb_lo_ff <= nxt_macb_lo;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      macb_hi_ff <= `TTM_RST_MACB_HI;
    end else begin
      macb_hi_ff <= nxt_macb_hi;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask_ff <= {`TTM_IRQ_W{1'b0}};
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // set wins over a same-cycle write-one clear so no mismatch is lost
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      chk_err_ff <= 1'b0;
    end else if (CHK_MISMATCH && chk_en_ff) begin
      chk_err_ff <= 1'b1; // RULE_04
    end else if (wr_hit(`TTM_OFS_CHK_STAT) && WDATA[`TTM_BIT_EN]) begin
      chk_err_ff <= 1'b0; // RULE_04
    end
  end
  assign chk_rise = CHK_MISMATCH & chk_en_ff & ~chk_err_ff;

  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_hit(`TTM_OFS_IRQ_STAT)) begin
      nxt_irq_stat = irq_stat_ff & ~WDATA[`TTM_IRQ_W-1:0];
    end
    if (chk_rise) begin
      nxt_irq_stat[`TTM_IRQ_CHK] = 1'b1;
    end
    if (rise_a) begin
      nxt_irq_stat[`TTM_IRQ_OVFA] = 1'b1;
    end
    if (rise_b) begin
      nxt_irq_stat[`TTM_IRQ_OVFB] = 1'b1;
    end
  end
  // status bits latch edges only, so a held event cannot refire after a clear
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_ff <= {`TTM_IRQ_W{1'b0}};
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // unmapped offsets and undefined bits read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (ADDR)
      `TTM_OFS_GEN_EN: nxt_rdata[`TTM_BIT_EN] = gen_en_ff; // RULE_11
      `TTM_OFS_PKT_LEN: nxt_rdata[15:0] = pkt_len_ff;
      `TTM_OFS_LB_CHK: begin
        nxt_rdata[`TTM_BIT_EN] = chk_en_ff;
        nxt_rdata[`TTM_BIT_LB] = lb_en_ff;
      end
      `TTM_OFS_CHK_STAT: nxt_rdata[`TTM_BIT_EN] = chk_err_ff;
      `TTM_OFS_SEQ_WRAP: nxt_rdata = wrap_ff;
      `TTM_OFS_MACA_FILT: begin
        nxt_rdata[`TTM_BIT_EN] = prom_a_ff;
        nxt_rdata[`TTM_BIT_OVF] = ovf_a; // RULE_07
      end
      `TTM_OFS_MACA_LO: nxt_rdata = maca_lo_ff;
      `TTM_OFS_MACA_HI: nxt_rdata[15:0] = maca_hi_ff;
      `TTM_OFS_MACB_FILT: begin
        nxt_rdata[`TTM_BIT_EN] = prom_b_ff;
        nxt_rdata[`TTM_BIT_OVF] = ovf_b; // RULE_09
      end
      `TTM_OFS_MACB_LO: nxt_rdata = macb_lo_ff;
      `TTM_OFS_MACB_HI: nxt_rdata[15:0] = macb_hi_ff;
      `TTM_OFS_IRQ_STAT: nxt_rdata[`TTM_IRQ_W-1:0] = irq_stat_ff;
      `TTM_OFS_IRQ_MASK: nxt_rdata[`TTM_IRQ_W-1:0] = irq_mask_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  // zero outside the read cycle keeps stale data off a shared return bus
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= nxt_rdata;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  assign GEN_ENABLE = gen_en_ff;
  assign PKT_LENGTH = pkt_len_ff;
  // oversized lengths are stored as written; the flag lets the generator refuse them
  assign PKT_LENGTH_ERR = (pkt_len_ff > `TTM_PKT_LEN_MAX); // RULE_02
  assign CHK_ENABLE = chk_en_ff;
  assign LOOPBACK_ENABLE = lb_en_ff;
  assign SEQ_WRAP = wrap_ff;
  assign MACA_PROMISC = prom_a_ff;
  assign MACA_ADDR = {maca_hi_ff, maca_lo_ff};
  assign MACB_PROMISC = prom_b_ff;
  assign MACB_ADDR = {macb_hi_ff, macb_lo_ff};
  assign IRQ = |(irq_stat_ff & irq_mask_ff);
endmodule
`default_nettype wire

// ---- ttm_regs_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module ttm_regs_properties (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic GEN_ENABLE,
  input wire logic [15:0] PKT_LENGTH,
  input wire logic CHK_ENABLE,
  input wire logic [31:0] SEQ_WRAP
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  property p_gen; WR && ADDR == 16'h9200 |=> GEN_ENABLE == $past(WDATA[0]); endproperty
  a_gen: assert property (p_gen) else $error("gen enable");
  property p_hold; !(WR && ADDR == 16'h9200) |=> $stable(GEN_ENABLE); endproperty
  a_hold: assert property (p_hold) else $error("gen hold");
  property p_len; WR && ADDR == 16'h9204 |=> PKT_LENGTH == $past(WDATA[15:0]); endproperty
  a_len: assert property (p_len) else $error("length");
  property p_chk; WR && ADDR == 16'h9208 |=> CHK_ENABLE == $past(WDATA[0]); endproperty
  a_chk: assert property (p_chk) else $error("chk enable");
  property p_wrap; WR && ADDR == 16'h9210 |=> SEQ_WRAP == $past(WDATA); endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_rgen; RD && ADDR == 16'h9200 |=> RDATA == {31'h0000_0000, GEN_ENABLE}; endproperty
  a_rgen: assert property (p_rgen) else $error("gen read");
  property p_rlen; RD && ADDR == 16'h9204 |=> RDATA == {16'h0000, PKT_LENGTH}; endproperty
  a_rlen: assert property (p_rlen) else $error("length read");
  property p_none; RD && ADDR == 16'h9300 |=> RDATA == 32'h0000_0000; endproperty
  a_none: assert property (p_none) else $error("unmapped read");
endmodule
bind ttm_regs ttm_regs_properties ttm_regs_properties_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .GEN_ENABLE(GEN_ENABLE),
  .PKT_LENGTH(PKT_LENGTH), .CHK_ENABLE(CHK_ENABLE), .SEQ_WRAP(SEQ_WRAP));
`default_nettype wire
